// ===== rtl/pcrs_pkg.sv
// Purpose: Shared constants and types for the program counter and return stack.
// Assumes: AXI4-Lite register access with 32-bit data and one aligned word per register.
// Notes: Register offsets, sizes, status and command bit positions used by the logic are named here.
package pcrs_pkg;
   // ----------------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------------
   localparam int PC_W = 21;
   localparam int PTR_W = 5;
   localparam int STK_DEPTH = 31;
   localparam int ADDR_W = 8;
   localparam int ST_W = 3;
   typedef logic [PC_W-1:0] pcrs_pc_t;
   typedef logic [ADDR_W-1:0] pcrs_addr_t;

   // ----------------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------------
   localparam pcrs_addr_t OFF_PC_LOW = 8'h00;
   localparam pcrs_addr_t OFF_HLAT = 8'h04;
   localparam pcrs_addr_t OFF_ULAT = 8'h08;
   localparam pcrs_addr_t OFF_TOP_LOW = 8'h0c;
   localparam pcrs_addr_t OFF_TOP_HIGH = 8'h10;
   localparam pcrs_addr_t OFF_TOP_UPPER = 8'h14;
   localparam pcrs_addr_t OFF_PTR = 8'h18;
   localparam pcrs_addr_t OFF_STAT = 8'h1c;
   localparam pcrs_addr_t OFF_CLR = 8'h20;
   localparam pcrs_addr_t OFF_EN = 8'h24;
   localparam pcrs_addr_t OFF_CMD = 8'h28;

   // ----------------------------------------------------------------------
   // Fields, values and steps
   // ----------------------------------------------------------------------
   localparam pcrs_pc_t PC_STEP = 21'h000002;
   localparam pcrs_pc_t PC_RESET = 21'h000000;
   localparam logic [PTR_W-1:0] PTR_EMPTY = 5'h00;
   localparam logic [PTR_W-1:0] PTR_NEAR = 5'h1e;
   localparam logic [PTR_W-1:0] PTR_MAX = 5'h1f;
   localparam int ST_FULL = 0;
   localparam int ST_OVF = 1;
   localparam int ST_UNF = 2;
   localparam int CMD_PUSH = 0;
   localparam int CMD_POP = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------------
   // Sequencer request bundle and bus states
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic advance;
      logic load;
      logic call;
      logic irq_ack;
      logic ret;
      pcrs_pc_t target;
   } pcrs_seq_t;
   typedef enum logic [1:0] {B_IDLE = 2'b00, B_EXEC = 2'b01, B_RESP = 2'b10} pcrs_bus_st_t;
endpackage : pcrs_pkg

// ===== rtl/pcrs_top.sv
// Purpose: Program counter with hidden upper bytes and a 31-entry return stack.
// Assumes: Sequencer requests arrive on CLOCK; software uses AXI4-Lite.
// Notes: Bus accesses wait while the sequencer is busy, so the two never collide.
//
// Chosen here: the AXI4-Lite slave port and the register offsets.

// Functional notes
// - Fetch address is 21 bits in three bytes.
// - Only low byte is software visible.
// - Low byte write loads upper bytes from latches.
// - Low byte read copies upper bytes to latches.
// - Counter bit zero always reads zero.
// - Sequential fetch adds two.
// - Jumps load counter directly, latches ignored.
// - Calls and interrupt acknowledges push, depth 31.
// - Returns pop the stack into counter.
// - Calls and returns leave latches unchanged.
// - Stack is 31 by 21 array, 5-bit pointer.
// - Software reaches pointer and top entry, pushes, pops.
// - Push increments pointer then stores counter.
// - Return pop loads counter then decrements pointer; software pop only decrements.
// - Reset clears pointer; zero means empty.
// - Full, overflow and underflow status bits.
// - Top registers track the selected entry.
module pcrs_top
   import pcrs_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   // Instruction sequencer requests
   input wire pcrs_seq_t SEQ,
   // AXI4-Lite write channels
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // AXI4-Lite read channels
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Core-facing state
   output logic [PC_W-1:0] PC_Q,
   output logic [PTR_W-1:0] PTR_Q,
   output logic IRQ_Q
);
   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   pcrs_pc_t pc_q;
   logic [7:0] hlat_q;
   logic [7:0] ulat_q;
   logic [PTR_W-1:0] ptr_q;
   pcrs_pc_t stk_q [1:STK_DEPTH];
   logic [ST_W-1:0] st_q;
   logic [ST_W-1:0] st_d;
   logic [ST_W-1:0] en_q;
   logic irq_q;
   pcrs_bus_st_t wst_q;
   pcrs_bus_st_t rst_q;
   logic awready_q, wready_q, aw_got_q, w_got_q, bvalid_q;
   logic arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   pcrs_addr_t waddr_q, raddr_q;
   logic [31:0] wdata_q;
   logic wlane_q;

   // ----------------------------------------------------------------------
   // Request decode
   // ----------------------------------------------------------------------
   logic seq_idle, aw_hs, w_hs, wr_fire, rd_fire;
   logic hw_push, sw_push, sw_pop, push_req, pop_req, push_ok;
   logic wr_low, wr_ptr, wr_top;
   pcrs_pc_t top_val;
   logic [ST_W-1:0] st_evt;

   // The bus acts only in cycles with no sequencer request, so the core never stalls.
   assign seq_idle = !(SEQ.advance | SEQ.load | SEQ.call | SEQ.irq_ack | SEQ.ret);
   assign aw_hs = S_AXI_AWVALID & awready_q;
   assign w_hs = S_AXI_WVALID & wready_q;
   assign wr_fire = (wst_q == B_EXEC) & seq_idle & wlane_q;
   assign rd_fire = (rst_q == B_EXEC) & seq_idle;
   assign wr_low = wr_fire & (waddr_q == OFF_PC_LOW);
   assign wr_ptr = wr_fire & (waddr_q == OFF_PTR);
   assign wr_top = wr_fire & (ptr_q != PTR_EMPTY) &
      ((waddr_q == OFF_TOP_LOW) | (waddr_q == OFF_TOP_HIGH) | (waddr_q == OFF_TOP_UPPER));

   // Stack traffic: return wins over a call presented in the same cycle.
   assign hw_push = (SEQ.call | SEQ.irq_ack) & !SEQ.ret;
   assign sw_push = wr_fire & (waddr_q == OFF_CMD) & wdata_q[CMD_PUSH];
   assign sw_pop = wr_fire & (waddr_q == OFF_CMD) & wdata_q[CMD_POP] & !wdata_q[CMD_PUSH];
   assign push_req = hw_push | sw_push;
   assign pop_req = SEQ.ret | sw_pop;
   assign push_ok = push_req & (ptr_q != PTR_MAX);
   // Pointer zero has no entry behind it, so it reads as all zero.
   assign top_val = (ptr_q == PTR_EMPTY) ? PC_RESET : stk_q[ptr_q];

   // ----------------------------------------------------------------------
   // Program counter
   // ----------------------------------------------------------------------
   // One update per cycle: return, then jump or call, then step, then software.
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         pc_q <= PC_RESET;
      end
      else if (SEQ.ret)
      begin
         pc_q <= {top_val[PC_W-1:1], 1'b0};
      end
      else if (SEQ.load | SEQ.call | SEQ.irq_ack)
      begin
         pc_q <= {SEQ.target[PC_W-1:1], 1'b0};
      end
      else if (SEQ.advance)
      begin
         pc_q <= pc_q + PC_STEP;
      end
      else if (wr_low)
      begin
         pc_q <= {ulat_q[4:0], hlat_q, wdata_q[7:1], 1'b0};
      end
   end

   // ----------------------------------------------------------------------
   // Latch registers
   // ----------------------------------------------------------------------
   // A direct latch write beats a same-cycle copy; calls and returns never touch them.
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         hlat_q <= 8'h00;
         ulat_q <= 8'h00;
      end
      else if (wr_fire & (waddr_q == OFF_HLAT))
      begin
         hlat_q <= wdata_q[7:0];
      end
      else if (wr_fire & (waddr_q == OFF_ULAT))
      begin
         ulat_q <= wdata_q[7:0];
      end
      else if (rd_fire & (raddr_q == OFF_PC_LOW))
      begin
         hlat_q <= pc_q[15:8];
         ulat_q <= {3'h0, pc_q[20:16]};
      end
   end

   // ----------------------------------------------------------------------
   // Return stack storage and pointer
   // ----------------------------------------------------------------------
   // Storage has no reset; only entries up to and including the pointer are meaningful.
   always_ff @(posedge CLOCK)
   begin
      if (push_ok)
      begin
         stk_q[ptr_q + 5'h01] <= pc_q;
      end
      else if (wr_top & (waddr_q == OFF_TOP_LOW))
      begin
         stk_q[ptr_q][7:0] <= wdata_q[7:0];
      end
      else if (wr_top & (waddr_q == OFF_TOP_HIGH))
      begin
         stk_q[ptr_q][15:8] <= wdata_q[7:0];
      end
      else if (wr_top)
      begin
         stk_q[ptr_q][20:16] <= wdata_q[4:0];
      end
   end

   // A refused push leaves the pointer at the top so no entry is overwritten.
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         ptr_q <= PTR_EMPTY;
      end
      else if (pop_req)
      begin
         if (ptr_q != PTR_EMPTY)
         begin
            ptr_q <= ptr_q - 5'h01;
         end
      end
      else if (push_ok)
      begin
         ptr_q <= ptr_q + 5'h01;
      end
      else if (wr_ptr)
      begin
         ptr_q <= wdata_q[PTR_W-1:0];
      end
   end

   // ----------------------------------------------------------------------
   // Status, enable and interrupt
   // ----------------------------------------------------------------------
   assign st_evt[ST_FULL] = push_ok & (ptr_q == PTR_NEAR);
   assign st_evt[ST_OVF] = push_req & (ptr_q == PTR_MAX);
   assign st_evt[ST_UNF] = pop_req & (ptr_q == PTR_EMPTY);
   // A new event wins over a clear written in the same cycle.
   always_comb
   begin
      st_d = st_q;
      if (wr_fire & (waddr_q == OFF_CLR))
      begin
         st_d = st_q & ~wdata_q[ST_W-1:0];
      end
      st_d = st_d | st_evt;
   end

   // The interrupt follows the next status so it lines up with the status register.
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         st_q <= '0;
         en_q <= '0;
         irq_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         if (wr_fire & (waddr_q == OFF_EN))
         begin
            en_q <= wdata_q[ST_W-1:0];
            irq_q <= |(st_d & wdata_q[ST_W-1:0]);
         end
         else
         begin
            irq_q <= |(st_d & en_q);
         end
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------------
   // Address and data are taken in either order; the write then waits for an idle sequencer.
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         wst_q <= B_IDLE;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         waddr_q <= '0;
         wdata_q <= '0;
         wlane_q <= 1'b0;
      end
      else
      begin
         case (wst_q)
            B_IDLE:
            begin
               awready_q <= !(aw_got_q | aw_hs);
               wready_q <= !(w_got_q | w_hs);
               if (aw_hs)
               begin
                  waddr_q <= S_AXI_AWADDR;
                  aw_got_q <= 1'b1;
               end
               if (w_hs)
               begin
                  wdata_q <= S_AXI_WDATA;
                  wlane_q <= S_AXI_WSTRB[0]; // Registers live in byte lane 0 only.
                  w_got_q <= 1'b1;
               end
               if ((aw_got_q | aw_hs) & (w_got_q | w_hs))
               begin
                  wst_q <= B_EXEC;
               end
            end
            B_EXEC:
            begin
               if (seq_idle)
               begin
                  bvalid_q <= 1'b1;
                  case (waddr_q)
                     OFF_PC_LOW, OFF_HLAT, OFF_ULAT, OFF_TOP_LOW, OFF_TOP_HIGH, OFF_TOP_UPPER,
                     OFF_PTR, OFF_STAT, OFF_CLR, OFF_EN, OFF_CMD: bresp_q <= RESP_OKAY;
                     default: bresp_q <= RESP_SLVERR;
                  endcase
                  wst_q <= B_RESP;
               end
            end
            B_RESP:
            begin
               if (S_AXI_BREADY)
               begin
                  bvalid_q <= 1'b0;
                  aw_got_q <= 1'b0;
                  w_got_q <= 1'b0;
                  awready_q <= 1'b1;
                  wready_q <= 1'b1;
                  wst_q <= B_IDLE;
               end
            end
            default:
            begin
               wst_q <= B_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------------
   logic [31:0] rd_data;
   logic rd_ok;
   // Write-only and unused bits read as zero.
   always_comb
   begin
      rd_data = '0;
      rd_ok = 1'b1;
      case (raddr_q)
         OFF_PC_LOW: rd_data[7:0] = pc_q[7:0];
         OFF_HLAT: rd_data[7:0] = hlat_q;
         OFF_ULAT: rd_data[7:0] = ulat_q;
         OFF_TOP_LOW: rd_data[7:0] = top_val[7:0];
         OFF_TOP_HIGH: rd_data[7:0] = top_val[15:8];
         OFF_TOP_UPPER: rd_data[4:0] = top_val[20:16];
         OFF_PTR: rd_data[PTR_W-1:0] = ptr_q;
         OFF_STAT: rd_data[ST_W-1:0] = st_q;
         OFF_EN: rd_data[ST_W-1:0] = en_q;
         OFF_CLR, OFF_CMD: rd_data = '0;
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         rst_q <= B_IDLE;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
         raddr_q <= '0;
      end
      else
      begin
         case (rst_q)
            B_IDLE:
            begin
               arready_q <= !(S_AXI_ARVALID & arready_q);
               if (S_AXI_ARVALID & arready_q)
               begin
                  raddr_q <= S_AXI_ARADDR;
                  rst_q <= B_EXEC;
               end
            end
            B_EXEC:
            begin
               if (seq_idle)
               begin
                  rdata_q <= rd_data;
                  rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
                  rvalid_q <= 1'b1;
                  rst_q <= B_RESP;
               end
            end
            B_RESP:
            begin
               if (S_AXI_RREADY)
               begin
                  rvalid_q <= 1'b0;
                  arready_q <= 1'b1;
                  rst_q <= B_IDLE;
               end
            end
            default:
            begin
               rst_q <= B_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign S_AXI_AWREADY = awready_q;
   assign S_AXI_WREADY = wready_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = arready_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;
   assign PC_Q = pc_q;
   assign PTR_Q = ptr_q;
   assign IRQ_Q = irq_q;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   chk_pc_aligned: assert property (@(posedge CLOCK) disable iff (RST) !pc_q[0])
      else $error("counter bit zero set");
   chk_seq_step: assert property (@(posedge CLOCK) disable iff (RST)
      (SEQ.advance & !SEQ.ret & !SEQ.load & !SEQ.call & !SEQ.irq_ack) |=> pc_q == $past(pc_q) + PC_STEP)
      else $error("sequential step is not two");
   chk_jump_direct: assert property (@(posedge CLOCK) disable iff (RST)
      (SEQ.load & !SEQ.ret) |=> pc_q == {$past(SEQ.target[PC_W-1:1]), 1'b0})
      else $error("jump target not loaded");
   chk_push_store: assert property (@(posedge CLOCK) disable iff (RST)
      (hw_push & ptr_q != PTR_MAX) |=> ptr_q == $past(ptr_q) + 5'h01 && top_val == $past(pc_q))
      else $error("push did not store counter");
   chk_pop_load: assert property (@(posedge CLOCK) disable iff (RST)
      (SEQ.ret & ptr_q != PTR_EMPTY) |=>
      pc_q == {$past(top_val[PC_W-1:1]), 1'b0} && ptr_q == $past(ptr_q) - 5'h01)
      else $error("return did not pop");
   chk_latch_keep: assert property (@(posedge CLOCK) disable iff (RST)
      (!seq_idle) |=> $stable(hlat_q) && $stable(ulat_q))
      else $error("latches moved on call or return");
   chk_low_write: assert property (@(posedge CLOCK) disable iff (RST)
      wr_low |=> pc_q[20:8] == {$past(ulat_q[4:0]), $past(hlat_q)})
      else $error("upper bytes not loaded from latches");
   chk_low_read: assert property (@(posedge CLOCK) disable iff (RST)
      (rd_fire & raddr_q == OFF_PC_LOW & !wr_fire) |=>
      hlat_q == $past(pc_q[15:8]) && ulat_q[4:0] == $past(pc_q[20:16]))
      else $error("latches not copied on read");
   chk_overflow: assert property (@(posedge CLOCK) disable iff (RST)
      (push_req & !pop_req & ptr_q == PTR_MAX) |=> ptr_q == PTR_MAX && st_q[ST_OVF])
      else $error("overflow not flagged");
   chk_underflow: assert property (@(posedge CLOCK) disable iff (RST)
      (pop_req & ptr_q == PTR_EMPTY) |=> ptr_q == PTR_EMPTY && st_q[ST_UNF])
      else $error("underflow not flagged");
   chk_reset_ptr: assert property (@(posedge CLOCK) $past(RST) |-> ptr_q == PTR_EMPTY && pc_q == PC_RESET)
      else $error("pointer not cleared by reset");
   chk_irq_level: assert property (@(posedge CLOCK) disable iff (RST) ##1 irq_q == |(st_q & en_q))
      else $error("interrupt does not follow status");
endmodule : pcrs_top

// ===== dv/pcrs_seq_mdl.sv
// Purpose: Instruction sequencer model that issues one request per call.
// Assumes: Each request lasts one cycle and is launched right after a rising edge.
// Notes: The bench never overlaps a request with a register access.
module pcrs_seq_mdl
   import pcrs_pkg::*;
(
   // Clock
   input wire logic clk,
   // Request bundle
   output pcrs_seq_t seq
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle until the bench asks for something.
   initial seq = '0;

   // ---------------------------------------------------------------
   // Request issue
   // ---------------------------------------------------------------
   // Kinds: 0 advance, 1 load, 2 call, 3 interrupt acknowledge, 4 return.
   // The target is inverted once the request ends, so a design that keeps
   // using a stale target shows it.
   task automatic issue(input int k, input pcrs_pc_t t);
      pcrs_seq_t r;
      pcrs_seq_t idle;
      r = '0;
      idle = '0;
      idle.target = ~t;
      r.target = t;
      r.advance = (k == 0);
      r.load = (k == 1);
      r.call = (k == 2);
      r.irq_ack = (k == 3);
      r.ret = (k == 4);
      seq <= r;
      @(posedge clk);
      seq <= idle;
      @(posedge clk);
   endtask : issue
endmodule : pcrs_seq_mdl

// ===== dv/program_counter_return_stack_tb.sv
// Purpose: Self-checking bench for the program counter and return stack.
// Assumes: Register accesses and sequencer requests never overlap.
// Notes: Every wait is bounded; a wait that runs out ends the run.
module program_counter_return_stack_tb;
   import pcrs_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   pcrs_seq_t seq;
   pcrs_addr_t awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   pcrs_pc_t pc;
   logic [PTR_W-1:0] ptr;
   int n_errors, n_checks;

   pcrs_seq_mdl sq (.clk(clk), .seq(seq));
   pcrs_top uut (.CLOCK(clk), .RST(rst), .SEQ(seq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PC_Q(pc), .PTR_Q(ptr),
      .IRQ_Q(irq));

   // 25 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // Checking and closing
   // ---------------------------------------------------------------
   task automatic results;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results

   // Case inequality so that an unknown never counts as a match.
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic st(input pcrs_pc_t p, input logic [PTR_W-1:0] s);
      chk("pc", 32'(p), 32'(pc));
      chk("ptr", 32'(s), 32'(ptr));
   endtask : st

   task automatic lim(input int n);
      if (n >= 100)
      begin
         n_errors++;
         $display("mismatch bus wait expected done seen timeout");
         results();
      end
   endtask : lim

   // ---------------------------------------------------------------
   // AXI4-Lite master
   // ---------------------------------------------------------------
   // Local flags track each channel, since the valid bits change by NBA.
   task automatic wr(input pcrs_addr_t a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic pa, pw;
      n = 0;
      pa = 1'b1;
      pw = 1'b1;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (pa && awready)
         begin
            pa = 1'b0;
            awvalid <= 1'b0;
         end
         if (pw && wready)
         begin
            pw = 1'b0;
            wvalid <= 1'b0;
         end
      end
      while ((pa || pw) && n < 100);
      lim(n);
      n = 0;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (!bvalid && n < 100);
      bready <= 1'b0;
      lim(n);
      chk("bresp", 32'(er), 32'(bresp));
   endtask : wr

   task automatic rd(input string nm, input pcrs_addr_t a, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (!arready && n < 100);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (!rvalid && n < 100);
      rready <= 1'b0;
      lim(n);
      chk("rresp", 32'(er), 32'(rresp));
      if (er == RESP_OKAY)
         chk(nm, e, rdata);
   endtask : rd

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      st(21'h000000, 5'h00);
      rd("status", OFF_STAT, 32'h0, RESP_OKAY);
      repeat (3) sq.issue(0, 21'h1fffff);
      st(21'h000006, 5'h00);
      wr(OFF_HLAT, 32'hab, RESP_OKAY);
      wr(OFF_ULAT, 32'h1c, RESP_OKAY);
      rd("hlat", OFF_HLAT, 32'hab, RESP_OKAY);
      sq.issue(1, 21'h012345);
      st(21'h012344, 5'h00);
      wr(OFF_PC_LOW, 32'h37, RESP_OKAY);
      st(21'h1cab36, 5'h00);
      sq.issue(2, 21'h000100);
      st(21'h000100, 5'h01);
      rd("top_low", OFF_TOP_LOW, 32'h36, RESP_OKAY);
      rd("top_high", OFF_TOP_HIGH, 32'hab, RESP_OKAY);
      rd("top_upper", OFF_TOP_UPPER, 32'h1c, RESP_OKAY);
      rd("ulat", OFF_ULAT, 32'h1c, RESP_OKAY);
      sq.issue(4, 21'h000000);
      st(21'h1cab36, 5'h00);
      rd("hlat", OFF_HLAT, 32'hab, RESP_OKAY);
      sq.issue(1, 21'h0a5b2c);
      rd("pc_low", OFF_PC_LOW, 32'h2c, RESP_OKAY);
      rd("hlat", OFF_HLAT, 32'h5b, RESP_OKAY);
      rd("ulat", OFF_ULAT, 32'h0a, RESP_OKAY);
      wr(OFF_CMD, 32'h1, RESP_OKAY);
      st(21'h0a5b2c, 5'h01);
      wr(OFF_TOP_LOW, 32'h41, RESP_OKAY);
      rd("top_low", OFF_TOP_LOW, 32'h41, RESP_OKAY);
      sq.issue(4, 21'h000000);
      st(21'h0a5b40, 5'h00);
      // Fill the stack with interrupt acknowledges, then overflow it.
      for (int i = 1; i <= 31; i++) sq.issue(3, pcrs_pc_t'(2 * i));
      st(21'h00003e, 5'h1f);
      rd("status", OFF_STAT, 32'h1, RESP_OKAY);
      sq.issue(2, 21'h0001fe);
      st(21'h0001fe, 5'h1f);
      rd("top_low", OFF_TOP_LOW, 32'h3c, RESP_OKAY);
      for (int i = 1; i <= 31; i++) sq.issue(4, 21'h000000);
      st(21'h0a5b40, 5'h00);
      sq.issue(4, 21'h000000);
      st(21'h000000, 5'h00);
      wr(OFF_STAT, 32'h0, RESP_OKAY);
      rd("status", OFF_STAT, 32'h7, RESP_OKAY);
      // Interrupt: raise, mask, raise again, clear.
      wr(OFF_EN, 32'h4, RESP_OKAY);
      chk("irq", 32'h1, 32'(irq));
      wr(OFF_EN, 32'h0, RESP_OKAY);
      chk("irq", 32'h0, 32'(irq));
      wr(OFF_EN, 32'h4, RESP_OKAY);
      wr(OFF_CLR, 32'h4, RESP_OKAY);
      chk("irq", 32'h0, 32'(irq));
      rd("status", OFF_STAT, 32'h3, RESP_OKAY);
      rd("unmapped", 8'h2c, 32'h0, RESP_SLVERR);
      wr(8'h30, 32'h1, RESP_SLVERR);
      wr(OFF_PTR, 32'h5, RESP_OKAY);
      st(21'h000000, 5'h05);
      rd("ptr", OFF_PTR, 32'h5, RESP_OKAY);
      // Software pop drops the top entry and leaves the counter alone.
      wr(OFF_CMD, 32'h2, RESP_OKAY);
      st(21'h000000, 5'h04);
      // A second reset in mid-run must empty the stack again.
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      st(21'h000000, 5'h00);
      results();
   end
endmodule : program_counter_return_stack_tb
